// ==== logic/uht_pkg.sv ====
// uht_pkg: shared constants and carriers for the endpoint halt and token status block
// assumes: one 100 MHz clock, AHB-Lite register access, 32-bit data bus
package uht_pkg;

  // bus and register widths
  localparam int DW     = 32;
  localparam int AW     = 8;
  localparam int RW     = 8;
  localparam int NEP    = 5;
  localparam int EPW    = 3;
  localparam int ADRW   = 7;
  localparam int NTF    = 3;
  localparam int NIRQ   = 5;

  // register byte offsets
  localparam logic [AW-1:0] OFS_HALT  = 8'h24;
  localparam logic [AW-1:0] OFS_TOKEN = 8'h28;
  localparam logic [AW-1:0] OFS_ADDR  = 8'h2c;
  localparam logic [AW-1:0] OFS_ISTAT = 8'h30;
  localparam logic [AW-1:0] OFS_IMASK = 8'h34;

  // token status field positions
  localparam int TB_DEFER = 0;
  localparam int TB_ERR   = 1;
  localparam int TB_OUT   = 2;
  localparam int TB_IN    = 3;
  localparam int TB_NAK   = 4;
  localparam int TB_PACKET_CHECK_FAIL_FLAG  = 5;
  localparam int TB_TACTN = 6;
  localparam int TB_NMASK = 7;

  // bit order of the small flag bank inside token status
  localparam int TF_ERR  = 0;
  localparam int TF_OUT  = 1;
  localparam int TF_PACKET_CHECK_FAIL_FLAG = 2;

  // interrupt status and mask layout
  localparam int IB_NAK   = 0;
  localparam int IB_ERR   = 1;
  localparam int IB_OUT   = 2;
  localparam int IB_PACKET_CHECK_FAIL_FLAG  = 3;
  localparam int IB_SETUP = 4;

  // address register layout: wake enable in bit 0, address above it
  localparam int AB_WAKE = 0;
  localparam int AB_LSB  = 1;

  // reset values
  localparam logic [NEP-1:0]  HALT_RST = 5'h00;
  localparam logic [NTF-1:0]  TF_RST   = 3'h0;
  localparam logic [NIRQ-1:0] IRQ_RST  = 5'h00;
  localparam logic [RW-1:0]   ADDR_RST = 8'h00;
  localparam logic [ADRW-1:0] DADR_RST = 7'h00;
  localparam logic            TACTN_RST = 1'b1;
  localparam logic [DW-1:0]   RD_ZERO  = 32'h0000_0000;

  // AHB response codes
  localparam logic HRESP_OKAY = 1'b0;

  // events and levels coming from the serial engine
  typedef struct packed {
    logic           busReset;        // usb bus reset seen, level
    logic           setupToken;      // valid setup token received, pulse
    logic           tokenStart;      // a new token packet begins, pulse
    logic           outToken;        // out token received, pulse
    logic           outZeroLen;      // qualifies outToken: zero length data
    logic           inToken;         // current token is an in token, level
    logic           nakSent;         // nak handshake sent, pulse
    logic           ep0Err;          // ep0 buffer access error, pulse
    logic           crcErr;          // crc error, pulse
    logic           pidErr;          // pid check error, pulse
    logic           tokenIncomplete; // truncated token, pulse
    logic           tokenActive;     // token packet in progress, level
    logic           inDone;          // host acked in data, pulse
    logic [EPW-1:0] tokenEp;         // endpoint of the current token
  } uht_sie_evt_t;

  // controls handed back to the serial engine
  typedef struct packed {
    logic [ADRW-1:0] deviceAddress;  // address the engine answers to
    logic [NEP-1:0]  haltBits;       // halted endpoints
    logic            stallReply;     // answer current token with stall
  } uht_sie_ctl_t;

endpackage

// ==== logic/uht_flag_bank.sv ====
// uht_flag_bank: a bank of flags that hardware sets and software loads or clears
// assumes: set, clr and load come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module uht_flag_bank #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // control
  input  wire logic [W-1:0] set,      // hardware set, wins over everything
  input  wire logic [W-1:0] clr,      // clear, wins over a load
  input  wire logic         load,     // software write of the whole bank
  input  wire logic [W-1:0] loadVal,  // value written
  // state
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;  // next flag values

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    next_q = ((load ? loadVal : q) & ~clr) | set;
  end

  // register the flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// ==== logic/uht_token_regs.sv ====
// uht_token_regs: endpoint halt and token status registers behind an AHB-Lite slave
// assumes: serial engine events arrive synchronous to clk; single word transfers only
//
// Summary of operation
// - halt bits cleared by bus reset, setup
// - halt bits five to seven read zero
// - deferred mode: address adopted after in done
// - immediate mode: address adopted on write
// - ep0 buffer error flag set, firmware clears
// - out flag set, except zero length out
// - out flag cleared by firmware or setup
// - read-only bit shows in token
// - read-only bit shows nak sent
// - packet check fail on crc, pid, truncation
// - token active flag low active, resets one
// - nak mask suppresses nak interrupt
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module uht_token_regs (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [uht_pkg::AW-1:0]    haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [uht_pkg::DW-1:0]    hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [uht_pkg::DW-1:0]         hrdata,
  // serial engine
  input  wire uht_pkg::uht_sie_evt_t     sieEvt,
  output uht_pkg::uht_sie_ctl_t          sieCtl,
  // interrupt
  output logic                           irq
);

  // bus pipeline state
  logic                    wrPend;       // write data phase in progress
  logic                    rdPend;       // read data phase in progress
  logic [uht_pkg::AW-1:0]  addrQ;        // latched address
  logic                    next_wrPend;
  logic                    next_rdPend;
  logic [uht_pkg::AW-1:0]  next_addrQ;
  logic                    next_hreadyout;
  logic [uht_pkg::DW-1:0]  next_hrdata;
  logic                    accept;       // address phase taken

  // write strobes decoded in the data phase
  logic                    wrHalt;
  logic                    wrTok;
  logic                    wrAddr;
  logic                    wrIstat;
  logic                    wrImask;
  logic [uht_pkg::RW-1:0]  wdat;         // low byte of write data

  // register state
  logic [uht_pkg::NEP-1:0]  halt;        // endpoint halt bits
  logic [uht_pkg::NTF-1:0]  tokFlags;    // err, out, packet_check_fail_flag
  logic [uht_pkg::NIRQ-1:0] istat;       // sticky interrupt status
  logic [uht_pkg::NIRQ-1:0] imask;       // interrupt mask
  logic                     deferAddr;   // deferred address update
  logic                     nakMask;     // nak interrupt mask
  logic                     inFlag;      // current token is in
  logic                     nakFlag;     // nak sent
  logic                     tokActN;     // token active, low active
  logic [uht_pkg::RW-1:0]   addrReg;     // device address register
  logic                     next_deferAddr;
  logic                     next_nakMask;
  logic                     next_inFlag;
  logic                     next_nakFlag;
  logic                     next_tokActN;
  logic [uht_pkg::NIRQ-1:0] next_imask;
  logic [uht_pkg::RW-1:0]   next_addrReg;

  // serial engine controls and interrupt output
  uht_pkg::uht_sie_ctl_t    next_sieCtl;
  logic                     next_irq;

  // flag bank inputs
  logic [uht_pkg::NEP-1:0]  haltClr;
  logic [uht_pkg::NTF-1:0]  tfSet;
  logic [uht_pkg::NTF-1:0]  tfClr;
  logic [uht_pkg::NTF-1:0]  tfLoad;
  logic [uht_pkg::NIRQ-1:0] irqSet;
  logic [uht_pkg::NIRQ-1:0] irqClr;
  logic [uht_pkg::RW-1:0]   tokRead;     // token status as read

  // address phase accepted when selected, non-idle and bus ready
  assign accept = hsel & htrans[1] & hready;
  assign wdat   = hwdata[uht_pkg::RW-1:0];

  // write decode, one strobe per register
  always_comb begin
    wrHalt  = 1'b0;
    wrTok   = 1'b0;
    wrAddr  = 1'b0;
    wrIstat = 1'b0;
    wrImask = 1'b0;
    if (!wrPend) begin
      // no write this cycle
    end else if (addrQ == uht_pkg::OFS_HALT) begin
      wrHalt = 1'b1;
    end else if (addrQ == uht_pkg::OFS_TOKEN) begin
      wrTok = 1'b1;
    end else if (addrQ == uht_pkg::OFS_ADDR) begin
      wrAddr = 1'b1;
    end else if (addrQ == uht_pkg::OFS_ISTAT) begin
      wrIstat = 1'b1;
    end else if (addrQ == uht_pkg::OFS_IMASK) begin
      wrImask = 1'b1;
    end
  end

  // halt bits: firmware writes them, reset and setup clear them
  assign haltClr = (sieEvt.busReset | sieEvt.setupToken) ? '1 : '0;
  uht_flag_bank #(
    .W   (uht_pkg::NEP),
    .RST (uht_pkg::HALT_RST)
  ) u_halt (
    .clk     (clk),
    .rstn    (rstn),
    .set     ('0),
    .clr     (haltClr),
    .load    (wrHalt),
    .loadVal (wdat[uht_pkg::NEP-1:0]),
    .q       (halt)
  );

  // token flags: engine sets, firmware write loads, setup clears out flag
  always_comb begin
    tfSet = '0;
    tfClr = '0;
    if (!sieEvt.busReset) begin
      tfSet[uht_pkg::TF_ERR]  = sieEvt.ep0Err;
      tfSet[uht_pkg::TF_OUT]  = sieEvt.outToken & ~sieEvt.outZeroLen;
      tfSet[uht_pkg::TF_PACKET_CHECK_FAIL_FLAG] = sieEvt.crcErr | sieEvt.pidErr
                              | sieEvt.tokenIncomplete;
      tfClr[uht_pkg::TF_OUT]  = sieEvt.setupToken;
    end else begin
      tfClr = '1;
    end
    tfLoad                   = '0;
    tfLoad[uht_pkg::TF_ERR]  = wdat[uht_pkg::TB_ERR];
    tfLoad[uht_pkg::TF_OUT]  = wdat[uht_pkg::TB_OUT];
    tfLoad[uht_pkg::TF_PACKET_CHECK_FAIL_FLAG] = wdat[uht_pkg::TB_PACKET_CHECK_FAIL_FLAG];
  end

  // firmware clears the flags by writing zero
  uht_flag_bank #(
    .W   (uht_pkg::NTF),
    .RST (uht_pkg::TF_RST)
  ) u_tok (
    .clk     (clk),
    .rstn    (rstn),
    .set     (tfSet),
    .clr     (tfClr),
    .load    (wrTok),
    .loadVal (tfLoad),
    .q       (tokFlags)
  );

  // interrupt events; a masked nak never reaches the status
  always_comb begin
    irqSet = '0;
    if (!sieEvt.busReset) begin
      irqSet[uht_pkg::IB_NAK]   = sieEvt.nakSent & ~nakMask;
      irqSet[uht_pkg::IB_ERR]   = tfSet[uht_pkg::TF_ERR];
      irqSet[uht_pkg::IB_OUT]   = tfSet[uht_pkg::TF_OUT];
      irqSet[uht_pkg::IB_PACKET_CHECK_FAIL_FLAG]  = tfSet[uht_pkg::TF_PACKET_CHECK_FAIL_FLAG];
      irqSet[uht_pkg::IB_SETUP] = sieEvt.setupToken;
    end
    irqClr = wrIstat ? wdat[uht_pkg::NIRQ-1:0] : '0;
  end

  // sticky status, write one to clear
  uht_flag_bank #(
    .W   (uht_pkg::NIRQ),
    .RST (uht_pkg::IRQ_RST)
  ) u_irq (
    .clk     (clk),
    .rstn    (rstn),
    .set     (irqSet),
    .clr     (irqClr),
    .load    (1'b0),
    .loadVal ('0),
    .q       (istat)
  );

  // plain control bits and read-only token state
  always_comb begin
    next_deferAddr = deferAddr;
    next_nakMask   = nakMask;
    next_imask     = imask;
    next_addrReg   = addrReg;
    next_inFlag    = sieEvt.inToken;
    next_tokActN   = ~sieEvt.tokenActive;
    next_nakFlag   = nakFlag;
    if (sieEvt.tokenStart) begin
      next_nakFlag = 1'b0;
    end
    if (sieEvt.nakSent) begin
      next_nakFlag = 1'b1;
    end
    if (wrTok) begin
      next_deferAddr = wdat[uht_pkg::TB_DEFER];
      next_nakMask   = wdat[uht_pkg::TB_NMASK];
    end
    if (wrImask) begin
      next_imask = wdat[uht_pkg::NIRQ-1:0];
    end
    if (wrAddr) begin
      next_addrReg = wdat;
    end
    if (sieEvt.busReset) begin
      next_deferAddr = 1'b0;
      next_nakMask   = 1'b0;
      next_nakFlag   = 1'b0;
      next_inFlag    = 1'b0;
      next_tokActN   = uht_pkg::TACTN_RST;
      next_addrReg   = uht_pkg::ADDR_RST;
    end
  end

  // register control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deferAddr <= 1'b0;
      nakMask   <= 1'b0;
      imask     <= uht_pkg::IRQ_RST;
      addrReg   <= uht_pkg::ADDR_RST;
      inFlag    <= 1'b0;
      nakFlag   <= 1'b0;
      tokActN   <= uht_pkg::TACTN_RST;
    end else begin
      deferAddr <= next_deferAddr;
      nakMask   <= next_nakMask;
      imask     <= next_imask;
      addrReg   <= next_addrReg;
      inFlag    <= next_inFlag;
      nakFlag   <= next_nakFlag;
      tokActN   <= next_tokActN;
    end
  end

  // controls to the engine: active address, halt copy, stall answer
  always_comb begin
    next_sieCtl          = sieCtl;
    next_sieCtl.haltBits = halt;
    if (sieEvt.busReset) begin
      next_sieCtl.deviceAddress = uht_pkg::DADR_RST;
    end else if (wrAddr && !deferAddr) begin
      // immediate mode takes the written address
      next_sieCtl.deviceAddress = wdat[uht_pkg::RW-1:uht_pkg::AB_LSB];
    end else if (sieEvt.inDone && deferAddr) begin
      // deferred mode waits for a completed in transfer
      next_sieCtl.deviceAddress = addrReg[uht_pkg::RW-1:uht_pkg::AB_LSB];
    end
    // stall only for an implemented endpoint inside an active token
    next_sieCtl.stallReply = 1'b0;
    if (sieEvt.tokenActive && (sieEvt.tokenEp < uht_pkg::EPW'(uht_pkg::NEP))) begin
      next_sieCtl.stallReply = halt[sieEvt.tokenEp];
    end
    next_irq = |(istat & imask);
  end

  // register engine controls and interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sieCtl.deviceAddress <= uht_pkg::DADR_RST;
      sieCtl.haltBits      <= uht_pkg::HALT_RST;
      sieCtl.stallReply    <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      sieCtl <= next_sieCtl;
      irq    <= next_irq;
    end
  end

  // token status as software sees it
  always_comb begin
    tokRead                   = '0;
    tokRead[uht_pkg::TB_DEFER] = deferAddr;
    tokRead[uht_pkg::TB_ERR]   = tokFlags[uht_pkg::TF_ERR];
    tokRead[uht_pkg::TB_OUT]   = tokFlags[uht_pkg::TF_OUT];
    tokRead[uht_pkg::TB_IN]    = inFlag;
    tokRead[uht_pkg::TB_NAK]   = nakFlag;
    tokRead[uht_pkg::TB_PACKET_CHECK_FAIL_FLAG]  = tokFlags[uht_pkg::TF_PACKET_CHECK_FAIL_FLAG];
    tokRead[uht_pkg::TB_TACTN] = tokActN;
    tokRead[uht_pkg::TB_NMASK] = nakMask;
  end

  // bus sequencing: reads take one wait state so data reflect last write
  always_comb begin
    next_wrPend    = accept & hwrite;
    next_rdPend    = accept & ~hwrite;
    next_addrQ     = accept ? haddr : addrQ;
    next_hreadyout = ~(accept & ~hwrite);
    next_hrdata    = hrdata;
    if (!rdPend) begin
      // keep last read data
    end else if (addrQ == uht_pkg::OFS_HALT) begin
      // unused upper halt bits read zero
      next_hrdata = uht_pkg::DW'(halt);
    end else if (addrQ == uht_pkg::OFS_TOKEN) begin
      next_hrdata = uht_pkg::DW'(tokRead);
    end else if (addrQ == uht_pkg::OFS_ADDR) begin
      next_hrdata = uht_pkg::DW'(addrReg);
    end else if (addrQ == uht_pkg::OFS_ISTAT) begin
      next_hrdata = uht_pkg::DW'(istat);
    end else if (addrQ == uht_pkg::OFS_IMASK) begin
      next_hrdata = uht_pkg::DW'(imask);
    end else begin
      next_hrdata = uht_pkg::RD_ZERO;
    end
  end

  // register bus state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend    <= 1'b0;
      rdPend    <= 1'b0;
      addrQ     <= '0;
      hreadyout <= 1'b1;
      hresp     <= uht_pkg::HRESP_OKAY;
      hrdata    <= uht_pkg::RD_ZERO;
    end else begin
      wrPend    <= next_wrPend;
      rdPend    <= next_rdPend;
      addrQ     <= next_addrQ;
      hreadyout <= next_hreadyout;
      hresp     <= uht_pkg::HRESP_OKAY;
      hrdata    <= next_hrdata;
    end
  end

endmodule
`default_nettype wire

// ==== tb/uht_token_regs_assertions.sv ====
// checker: bus timing, halt clearing and stall answer at the token register ports
// assumes: bound to uht_token_regs, one clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module uht_token_regs_assertions (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // bus side
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [uht_pkg::DW-1:0] hrdata,
  // engine side
  input wire uht_pkg::uht_sie_evt_t  sieEvt,
  input wire uht_pkg::uht_sie_ctl_t  sieCtl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a request that the slave takes at this edge
  wire logic taken = hsel && htrans[1] && hready;

  property p_okay; hresp == uht_pkg::HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait; taken && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_hold; $past(hreadyout) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved between reads");
  property p_upper; hrdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  property p_setup; sieEvt.setupToken |-> ##2 sieCtl.haltBits == 5'h00; endproperty
  a_setup: assert property (p_setup) else $error("halt kept after setup");
  property p_busrst;
    sieEvt.busReset |-> ##2 (sieCtl.haltBits == 5'h00 && sieCtl.deviceAddress == 7'h00);
  endproperty
  a_busrst: assert property (p_busrst) else $error("state kept after bus reset");
  property p_stall;
    $past(rstn) |-> sieCtl.stallReply == ($past(sieEvt.tokenActive)
      && $past(sieEvt.tokenEp) < 3'h5 && sieCtl.haltBits[$past(sieEvt.tokenEp)]);
  endproperty
  a_stall: assert property (p_stall) else $error("stall answer wrong");
  // main scenarios reached
  c_read: cover property (taken && !hwrite);
  c_setup: cover property (sieEvt.setupToken);
  c_stall: cover property (sieCtl.stallReply);
endmodule
bind uht_token_regs uht_token_regs_assertions chk_u (.clk(clk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sieEvt(sieEvt), .sieCtl(sieCtl));
`default_nettype wire

// ==== tb/uht_sie_model.sv ====
// partner: engine side, turns host traffic into event pulses and token levels
// assumes: fire is called right after a rising edge, one call at a time
`timescale 1ns/10ps
`default_nettype none
module uht_sie_model (
  // clock
  input  wire logic             clk,
  // events toward the block
  output var uht_pkg::uht_sie_evt_t sieEvt
);
  // quiet bus at start
  initial sieEvt = '0;
  // drive e for one cycle, keep its levels for len cycles, then go idle
  task automatic fire(input uht_pkg::uht_sie_evt_t e, input int len);
    uht_pkg::uht_sie_evt_t lvl;
    lvl = '0;
    lvl.busReset = e.busReset;
    lvl.inToken = e.inToken; // in level stands for the whole token
    lvl.tokenActive = e.tokenActive;
    lvl.tokenEp = e.tokenEp;
    sieEvt <= e;
    for (int i = 1; i < len; i++) begin
      @(posedge clk);
      sieEvt <= lvl;
    end
    @(posedge clk);
    // endpoint field is meaningless when idle: show the inverse, not a stale copy
    sieEvt <= '{tokenEp: ~e.tokenEp, default: '0};
  endtask
endmodule
`default_nettype wire

// ==== tb/usb_endpoint_halt_and_token_status_test.sv ====
// testbench: register map, event flags, address update, stall and interrupt of the token block
// assumes: one bus master here, engine events from the partner model
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_halt_and_token_status_test;
  // clock, reset and bus
  logic                  clk;
  logic                  rstn;
  logic                  hsel;
  logic [7:0]            haddr;
  logic [1:0]            htrans;
  logic                  hwrite;
  logic [31:0]           hwdata;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           hrdata;
  logic                  irq;
  uht_pkg::uht_sie_evt_t sieEvt;
  uht_pkg::uht_sie_ctl_t sieCtl;
  uht_pkg::uht_sie_evt_t ev;
  // counters and last read word
  int                    n_fail;
  int                    tests_run;
  logic [31:0]           q;
  // row: address, write first, written value, value read back
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x;} uht_row_t;
  uht_row_t rows [9] = '{'{8'h24, 1'b0, 32'h00, 32'h00}, '{8'h28, 1'b0, 32'h00, 32'h40},
    '{8'h24, 1'b1, 32'hff, 32'h1f}, '{8'h28, 1'b1, 32'hff, 32'he7},
    '{8'h28, 1'b1, 32'h00, 32'h40}, '{8'h40, 1'b1, 32'hff, 32'h00},
    '{8'h34, 1'b1, 32'h1f, 32'h1f}, '{8'h24, 1'b1, 32'h00, 32'h00},
    '{8'h2c, 1'b1, 32'h0a, 32'h0a}};

  uht_token_regs dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sieEvt(sieEvt), .sieCtl(sieCtl), .irq(irq));
  uht_sie_model host_u (.clk(clk), .sieEvt(sieEvt));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ready as it will be sampled at the coming edge, bounded
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // one single transfer; entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // called at a negedge: look, then realign to a rising edge
  task automatic look(input logic [31:0] seen, input logic [31:0] exp);
    chk(seen, exp);
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values and register map
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a);
      chk(q, rows[i].x);
    end
    $display("test register map done");
    // in token on a halted endpoint, then out and setup
    wr(8'h24, 32'h14);
    fork
      host_u.fire('{tokenStart: 1'b1, tokenActive: 1'b1, inToken: 1'b1, tokenEp: 3'h2,
        default: '0}, 12);
      begin
        rd(8'h28);
        chk(q & 32'h48, 32'h08);
        @(negedge clk);
        chk({31'h0, sieCtl.stallReply}, 32'h1);
      end
    join
    // the model just went idle in this time step: let one edge pass before the next event
    @(posedge clk);
    host_u.fire('{outToken: 1'b1, default: '0}, 1);
    rd(8'h28);
    chk(q & 32'h04, 32'h04);
    host_u.fire('{setupToken: 1'b1, default: '0}, 1);
    rd(8'h24);
    chk(q, 32'h00);
    rd(8'h28);
    chk(q & 32'h04, 32'h00);
    host_u.fire('{outToken: 1'b1, outZeroLen: 1'b1, default: '0}, 1);
    rd(8'h28);
    chk(q & 32'h04, 32'h00);
    $display("test halt and tokens done");
    // each error source sets its flag; firmware clears it
    for (int i = 0; i < 4; i++) begin
      ev = '0;
      case (i)
        0: ev.ep0Err = 1'b1;
        1: ev.crcErr = 1'b1;
        2: ev.pidErr = 1'b1;
        default: ev.tokenIncomplete = 1'b1;
      endcase
      host_u.fire(ev, 1);
      rd(8'h28);
      chk(q & 32'h22, (i == 0) ? 32'h02 : 32'h20);
      wr(8'h28, 32'h00);
      rd(8'h28);
      chk(q & 32'h22, 32'h00);
    end
    $display("test error flags done");
    // nak interrupt raised, cleared, then masked
    wr(8'h30, 32'h1f);
    wr(8'h34, 32'h01);
    host_u.fire('{nakSent: 1'b1, default: '0}, 1);
    rd(8'h28);
    chk(q & 32'h10, 32'h10);
    chk({31'h0, irq}, 32'h1);
    wr(8'h30, 32'h01);
    rd(8'h30);
    chk({31'h0, irq}, 32'h0);
    wr(8'h28, 32'h80);
    host_u.fire('{nakSent: 1'b1, default: '0}, 1);
    rd(8'h28);
    chk({31'h0, irq}, 32'h0);
    $display("test nak interrupt done");
    // immediate, then deferred address update
    wr(8'h28, 32'h00);
    wr(8'h2c, 32'h1c); // immediate mode: address 0x0e adopted on the write
    @(posedge clk);
    @(negedge clk);
    look({25'h0, sieCtl.deviceAddress}, 32'h0e);
    wr(8'h28, 32'h01);
    wr(8'h2c, 32'h22);
    repeat (3) @(negedge clk);
    look({25'h0, sieCtl.deviceAddress}, 32'h0e);
    host_u.fire('{inDone: 1'b1, default: '0}, 1);
    @(negedge clk);
    look({25'h0, sieCtl.deviceAddress}, 32'h11);
    host_u.fire('{setupToken: 1'b1, default: '0}, 1);
    wr(8'h28, 32'h00); // firmware leaves deferred mode after setup
    $display("test address update done");
    // bus reset clears halt, token state and address, keeps the mask
    wr(8'h24, 32'h1f);
    host_u.fire('{busReset: 1'b1, default: '0}, 2);
    rd(8'h24);
    chk(q, 32'h00);
    rd(8'h28);
    chk(q, 32'h40);
    rd(8'h34);
    chk(q, 32'h01);
    $display("test bus reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
